// [design/fsp_guard.sv]
// Guarded-sequence watcher for the protected mode-control register
`timescale 1ns/1ps
module fsp_guard (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Peripheral store seen on the register bus
  input wire logic store,
  input wire logic [15:0] store_idx,
  input wire logic [7:0] store_data,
  // Results
  output logic mode_load,
  output logic [7:0] mode_value,
  output logic err
);
  fsp_pkg::fsp_guard_s r;
  fsp_pkg::fsp_guard_s n;
  logic is_mode;
  logic is_unlock;
  logic inv_ok;

  assign is_mode = (store_idx == fsp_pkg::IDX_MODE);
  assign is_unlock = (store_idx == fsp_pkg::IDX_UNLOCK);
  assign inv_ok = is_mode && (store_data == ~r.saved);

  always_comb begin
    n = r;
    n.mode_load = 1'b0;
    n.err = 1'b0;
    if (store) begin
      case (r.state)
        fsp_pkg::G_IDLE: begin
          if (is_unlock) begin
            if (store_data == fsp_pkg::UNLOCK_KEY) begin
              n.state = fsp_pkg::G_UNLOCKED;
            end else begin
              n.err = 1'b1;
            end
          end else if (is_mode) begin
            n.err = 1'b1;
          end
        end
        fsp_pkg::G_UNLOCKED: begin
          if (is_mode) begin
            n.saved = store_data;
            n.state = fsp_pkg::G_FIRST;
          end else begin
            n.err = 1'b1;
            n.state = fsp_pkg::G_IDLE;
          end
        end
        fsp_pkg::G_FIRST: begin
          n.state = inv_ok ? fsp_pkg::G_SECOND : fsp_pkg::G_IDLE;
          n.err = !inv_ok;
        end
        fsp_pkg::G_SECOND: begin
          n.state = fsp_pkg::G_IDLE;
          if (is_mode && store_data == r.saved) begin
            // Only this final store reaches the mode-control register
            n.mode_load = 1'b1;
            n.mode_value = store_data;
          end else begin
            n.err = 1'b1;
          end
        end
        default: n.state = fsp_pkg::G_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign mode_load = r.mode_load;
  assign mode_value = r.mode_value;
  assign err = r.err;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_final_good;
    store && r.state == fsp_pkg::G_SECOND && is_mode && store_data == r.saved;
  endsequence
  sequence s_loaded;
    mode_load && !err ##0 r.state == fsp_pkg::G_IDLE;
  endsequence

  a_final_loads: assert property (s_final_good |=> s_loaded)
    else $error("final guarded store did not load");
  a_direct_blocked: assert property (store && r.state == fsp_pkg::G_IDLE && is_mode |=> err && !mode_load)
    else $error("unguarded mode write not blocked");
  a_bad_inverse: assert property (store && r.state == fsp_pkg::G_FIRST && !inv_ok |=> err && r.state == fsp_pkg::G_IDLE)
    else $error("bad inverse store not flagged");
  a_wrong_target: assert property (store && r.state != fsp_pkg::G_IDLE && !is_mode |=> err && !mode_load)
    else $error("store to other register not flagged");
  a_bad_final: assert property (store && r.state == fsp_pkg::G_SECOND && is_mode && store_data != r.saved |=> err)
    else $error("mismatched final store not flagged");
endmodule

// [design/fsp_pkg.sv]
// Constants and types shared by the flash self-programming status and command block
package fsp_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [15:0] IDX_CMD = 16'hFFA0;
  localparam logic [15:0] IDX_STATUS = 16'hFFA1;
  localparam logic [15:0] IDX_MODE = 16'hFFA2;
  localparam logic [15:0] IDX_UNLOCK = 16'hFFA3;
  localparam logic [15:0] IDX_PTR_H = 16'hFFA4;
  localparam logic [15:0] IDX_PTR_L = 16'hFFA5;
  localparam int ADR_W = 18;
  // Status flag positions
  localparam int BIT_PROT = 0;
  localparam int BIT_VERIFY = 1;
  localparam int BIT_AREA = 2;
  localparam int STATUS_W = 3;
  localparam int CMD_W = 3;
  // Values after reset; pointer contents are undefined, zero is used
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Unlock key for the guarded sequence
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  // Command codes
  localparam logic [2:0] CMD_VERIFY = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h3;
  localparam logic [2:0] CMD_BLANK = 3'h4;
  localparam logic [2:0] CMD_WRITE = 3'h5;

  typedef enum logic [1:0] {G_IDLE, G_UNLOCKED, G_FIRST, G_SECOND} fsp_guard_e;
  typedef enum logic [0:0] {S_IDLE, S_RUN} fsp_seq_e;

  typedef struct packed {
    fsp_guard_e state;
    logic [7:0] saved;
    logic mode_load;
    logic [7:0] mode_value;
    logic err;
  } fsp_guard_s;

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic [STATUS_W-1:0] status;
    logic [CMD_W-1:0] cmd;
    logic [7:0] ptr_h;
    logic [7:0] ptr_l;
    fsp_seq_e seq;
    logic start;
    logic exit;
  } fsp_top_s;
endpackage

// [design/fsp_status_cmd.sv]
// Flash self-programming status, command and address-pointer block with Wishbone slave
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fsp_status_cmd (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fsp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode-control register link
  output logic mode_ctrl_load,
  output logic [7:0] mode_ctrl_value,
  input wire logic self_prog_mode,
  input wire logic cpu_halt,
  output logic self_prog_exit,
  // Compare registers and protect decoder
  input wire logic [7:0] addr_compare_high,
  input wire logic [7:0] addr_compare_low,
  input wire logic block_protected,
  // Flash array sequencer
  output logic flash_start,
  output logic [2:0] flash_cmd,
  output logic [15:0] flash_addr,
  output logic flash_busy,
  input wire logic flash_step,
  input wire logic flash_done,
  input wire logic flash_verify_fail
);
  fsp_pkg::fsp_top_s r;
  fsp_pkg::fsp_top_s n;
  logic req;
  logic wr;
  logic [15:0] idx;
  logic [7:0] wdat;
  logic prot_set;
  logic cmd_valid;
  logic trigger;
  logic at_end;

  assign req = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[fsp_pkg::ADR_W-1:2];
  assign wdat = wb_dat_i[7:0];
  assign cmd_valid = (r.cmd == fsp_pkg::CMD_VERIFY) || (r.cmd == fsp_pkg::CMD_ERASE) ||
                     (r.cmd == fsp_pkg::CMD_BLANK) || (r.cmd == fsp_pkg::CMD_WRITE);
  // Exit pulse masks the trigger while the mode bit is still being cleared outside
  assign trigger = (r.seq == fsp_pkg::S_IDLE) && self_prog_mode && cpu_halt && !r.exit;
  assign at_end = ({r.ptr_h, r.ptr_l} == {addr_compare_high, addr_compare_low});

  fsp_guard u_guard (
    .clock(clock),
    .rst_n(rst_n),
    .store(wr),
    .store_idx(idx),
    .store_data(wdat),
    .mode_load(mode_ctrl_load),
    .mode_value(mode_ctrl_value),
    .err(prot_set)
  );

  always_comb begin
    logic [fsp_pkg::STATUS_W-1:0] stat;
    logic [fsp_pkg::STATUS_W-1:0] set_vec;
    stat = r.status;
    set_vec = '0;
    n = r;
    n.ack = req;
    n.start = 1'b0;
    n.exit = 1'b0;
    set_vec[fsp_pkg::BIT_PROT] = prot_set;
    // Command sequencer
    case (r.seq)
      fsp_pkg::S_IDLE: begin
        if (trigger) begin
          if (!cmd_valid) begin
            n.exit = 1'b1;
          end else if (block_protected && r.cmd != fsp_pkg::CMD_BLANK) begin
            set_vec[fsp_pkg::BIT_AREA] = 1'b1;
            n.exit = 1'b1;
          end else begin
            n.start = 1'b1;
            n.seq = fsp_pkg::S_RUN;
          end
        end
      end
      fsp_pkg::S_RUN: begin
        if (flash_step && !at_end) begin
          {n.ptr_h, n.ptr_l} = {r.ptr_h, r.ptr_l} + 16'h0001;
        end
        if (flash_done) begin
          set_vec[fsp_pkg::BIT_VERIFY] = flash_verify_fail;
          n.exit = 1'b1;
          n.seq = fsp_pkg::S_IDLE;
        end
      end
      default: n.seq = fsp_pkg::S_IDLE;
    endcase
    // Register writes; a later software write to a pointer overrides the count
    if (wr) begin
      case (idx)
        fsp_pkg::IDX_STATUS: stat = stat & wdat[fsp_pkg::STATUS_W-1:0];
        fsp_pkg::IDX_CMD: n.cmd = wdat[fsp_pkg::CMD_W-1:0];
        fsp_pkg::IDX_PTR_H: n.ptr_h = wdat;
        fsp_pkg::IDX_PTR_L: n.ptr_l = wdat;
        default: n.cmd = n.cmd;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    n.status = stat | set_vec;
    // Read mux; unmapped, mode and unlock indices read zero
    n.dat = 8'h00;
    if (req && !wb_we_i) begin
      case (idx)
        fsp_pkg::IDX_STATUS: n.dat = {5'h00, r.status};
        fsp_pkg::IDX_CMD: n.dat = {5'h00, r.cmd};
        fsp_pkg::IDX_PTR_H: n.dat = r.ptr_h;
        fsp_pkg::IDX_PTR_L: n.dat = r.ptr_l;
        default: n.dat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
      r.status <= fsp_pkg::STATUS_RESET;
      r.cmd <= fsp_pkg::CMD_RESET;
      r.ptr_h <= fsp_pkg::PTR_RESET;
      r.ptr_l <= fsp_pkg::PTR_RESET;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = {24'h000000, r.dat};
  assign self_prog_exit = r.exit;
  assign flash_start = r.start;
  assign flash_cmd = r.cmd;
  assign flash_addr = {r.ptr_h, r.ptr_l};
  assign flash_busy = (r.seq == fsp_pkg::S_RUN);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_status_clear0;
    wr && idx == fsp_pkg::IDX_STATUS && !wdat[0] && !prot_set;
  endsequence

  a_ack_follows: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given for exactly one cycle");
  a_prot_clear: assert property (s_status_clear0 |=> !r.status[fsp_pkg::BIT_PROT])
    else $error("protection flag not cleared by zero write");
  a_prot_set: assert property (prot_set |=> r.status[fsp_pkg::BIT_PROT])
    else $error("protection flag not set on sequence error");
  a_ones_keep: assert property (wr && idx == fsp_pkg::IDX_STATUS && wdat[2:0] == 3'h7 && !prot_set &&
                                !trigger && r.seq == fsp_pkg::S_IDLE |=> $stable(r.status))
    else $error("writing ones changed status");
  a_bad_cmd_exit: assert property (trigger && !cmd_valid && !wr |=>
                                   self_prog_exit && !flash_start && $stable(r.status[2:1]))
    else $error("undefined command not handled");
  a_area_block: assert property (trigger && cmd_valid && block_protected && r.cmd != fsp_pkg::CMD_BLANK
                                 |=> r.status[fsp_pkg::BIT_AREA] && !flash_start ##1 !flash_busy)
    else $error("protected block not refused");
  a_verify_fail: assert property (flash_busy && flash_done && flash_verify_fail |=>
                                  r.status[fsp_pkg::BIT_VERIFY] && self_prog_exit && !flash_busy)
    else $error("verify failure not flagged");
  a_ptr_stop: assert property (flash_busy && flash_step && at_end && !wr |=> $stable(flash_addr))
    else $error("pointer counted past compare");
  a_ptr_count: assert property (flash_busy && flash_step && !at_end && !wr |=>
                                flash_addr == $past(flash_addr) + 16'h0001)
    else $error("pointer did not increment");
  // The default disable would switch this check off whenever its antecedent holds
  a_reset_vals: assert property (@(posedge clock) disable iff (1'b0) !rst_n |=> r.status == 3'h0 && r.cmd == 3'h0)
    else $error("status or command not cleared by reset");
endmodule

// [test/fsp_flash_model.sv]
// Behavioural flash array sequencer answering start pulses with steps and done
`timescale 1ns/1ps
module fsp_flash_model (
  // Clock
  input wire logic clock,
  // Control from the block and the bench
  input wire logic flash_start,
  input wire logic fail,
  input wire logic [3:0] gap,
  // Answers to the block
  output logic flash_step,
  output logic flash_done,
  output logic flash_verify_fail
);
  logic toggle = 1'b0;
  always @(posedge clock) toggle <= ~toggle;
  // Fail only means something with done; elsewhere it wanders so nothing can lean on it
  assign flash_verify_fail = flash_done ? fail : toggle;
  initial begin
    flash_step = 1'b0;
    flash_done = 1'b0;
  end
  always @(posedge clock) begin
    if (flash_start === 1'b1) begin
      repeat (gap) @(posedge clock);
      for (int i = 0; i < 3; i++) begin
        flash_step <= 1'b1;
        @(posedge clock);
        flash_step <= 1'b0;
        @(posedge clock);
        repeat (gap) @(posedge clock);
      end
      flash_done <= 1'b1;
      @(posedge clock);
      flash_done <= 1'b0;
    end
  end
endmodule

// [test/fsp_status_cmd_tb.sv]
// Self-checking bench for the flash self-programming status and command block
`timescale 1ns/1ps
module fsp_status_cmd_tb;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mode_ctrl_load, cpu_halt, self_prog_exit;
  logic block_protected, flash_start, flash_busy, flash_step, flash_done, flash_verify_fail, fail;
  logic self_prog_mode = 1'b0;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i, gap;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] mode_ctrl_value, addr_compare_high, addr_compare_low, last_val;
  logic [2:0] flash_cmd;
  logic [15:0] flash_addr;
  int n_errors = 0, comparisons = 0, n_load = 0, n_start = 0, n_exit = 0, n_busy = 0;

  fsp_status_cmd dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mode_ctrl_load, .mode_ctrl_value, .self_prog_mode, .cpu_halt, .self_prog_exit,
    .addr_compare_high, .addr_compare_low, .block_protected, .flash_start, .flash_cmd, .flash_addr,
    .flash_busy, .flash_step, .flash_done, .flash_verify_fail);
  fsp_flash_model partner (.clock, .flash_start, .fail, .gap, .flash_step, .flash_done, .flash_verify_fail);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Mode bit of the external mode-control register, and event counters
  always @(posedge clock) begin
    if (!rst_n) self_prog_mode <= 1'b0;
    else if (self_prog_exit === 1'b1) self_prog_mode <= 1'b0;
    else if (mode_ctrl_load === 1'b1) self_prog_mode <= mode_ctrl_value[0];
    if (mode_ctrl_load === 1'b1) begin
      n_load <= n_load + 1;
      last_val <= mode_ctrl_value;
    end
    if (flash_start === 1'b1) n_start <= n_start + 1;
    if (self_prog_exit === 1'b1) n_exit <= n_exit + 1;
    if (flash_busy === 1'b1) n_busy <= n_busy + 1;
  end

  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    check("bus ack", {7'h00, wb_ack_o}, 8'h01);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check($sformatf("reg %h", idx), q, exp);
  endtask

  // After a broken sequence: flag up, no load, then cleared by a zero in bit 0 only
  task automatic err_done();
    rd(fsp_pkg::IDX_STATUS, 8'h01);
    check("mode loads", n_load[7:0], 8'h01);
    wr(fsp_pkg::IDX_STATUS, 8'h06);
    rd(fsp_pkg::IDX_STATUS, 8'h00);
  endtask

  task automatic guard(input logic [7:0] v);
    wr(fsp_pkg::IDX_UNLOCK, 8'hA5);
    wr(fsp_pkg::IDX_MODE, v);
    wr(fsp_pkg::IDX_MODE, ~v);
    wr(fsp_pkg::IDX_MODE, v);
    // Let the load counter settle before anyone reads it
    @(posedge clock);
  endtask

  task automatic run(input logic [2:0] code, input logic p);
    logic ok, go;
    logic [7:0] es;
    int s0, e0, k, b0;
    ok = code inside {3'h1, 3'h3, 3'h4, 3'h5};
    go = ok && !(p && code != 3'h4);
    es = !ok ? 8'h00 : (p && code != 3'h4) ? 8'h04 : (code[0] ? 8'h02 : 8'h00);
    wr(fsp_pkg::IDX_STATUS, 8'h00);
    wr(fsp_pkg::IDX_PTR_H, 8'h01);
    wr(fsp_pkg::IDX_PTR_L, 8'hFD);
    wr(fsp_pkg::IDX_CMD, {5'h00, code});
    block_protected <= p;
    fail <= code[0];
    gap <= code[1] ? 4'h3 : 4'h0;
    guard(8'h01);
    s0 = n_start;
    e0 = n_exit;
    b0 = n_busy;
    k = 0;
    cpu_halt <= 1'b1;
    while (n_exit == e0 && k < 100) begin
      @(posedge clock);
      k++;
    end
    cpu_halt <= 1'b0;
    check("exit seen", 8'(n_exit - e0), 8'h01);
    check("starts", 8'(n_start - s0), {7'h00, go});
    check("command", {5'h00, flash_cmd}, {5'h00, code});
    check("busy seen", {7'h00, n_busy != b0}, {7'h00, go});
    check("busy after", {7'h00, flash_busy}, 8'h00);
    check("addr high", flash_addr[15:8], 8'h01);
    rd(fsp_pkg::IDX_STATUS, es);
    rd(fsp_pkg::IDX_PTR_L, go ? 8'hFF : 8'hFD);
    wr(fsp_pkg::IDX_STATUS, 8'hFF);
    rd(fsp_pkg::IDX_STATUS, es);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, cpu_halt, block_protected, fail} = 7'h00;
    wb_adr_i = 18'h00000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    gap = 4'h0;
    addr_compare_high = 8'h01;
    addr_compare_low = 8'hFF;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(fsp_pkg::IDX_STATUS, 8'h00);
    rd(fsp_pkg::IDX_CMD, 8'h00);
    rd(16'h0123, 8'h00);
    wr(fsp_pkg::IDX_CMD, 8'hFF);
    rd(fsp_pkg::IDX_CMD, 8'h07);
    wr(fsp_pkg::IDX_STATUS, 8'hFF);
    rd(fsp_pkg::IDX_STATUS, 8'h00);
    wr(fsp_pkg::IDX_PTR_H, 8'h3C);
    rd(fsp_pkg::IDX_PTR_H, 8'h3C);
    guard(8'h01);
    check("mode loads", n_load[7:0], 8'h01);
    check("mode value", last_val, 8'h01);
    rd(fsp_pkg::IDX_STATUS, 8'h00);
    wr(fsp_pkg::IDX_UNLOCK, 8'h5A);
    err_done();
    wr(fsp_pkg::IDX_MODE, 8'h01);
    err_done();
    wr(fsp_pkg::IDX_UNLOCK, 8'hA5);
    wr(fsp_pkg::IDX_PTR_L, 8'h12);
    err_done();
    wr(fsp_pkg::IDX_UNLOCK, 8'hA5);
    wr(fsp_pkg::IDX_UNLOCK, 8'hA5);
    err_done();
    wr(fsp_pkg::IDX_UNLOCK, 8'hA5);
    wr(fsp_pkg::IDX_MODE, 8'h01);
    wr(fsp_pkg::IDX_MODE, 8'h00);
    err_done();
    wr(fsp_pkg::IDX_UNLOCK, 8'hA5);
    wr(fsp_pkg::IDX_MODE, 8'h01);
    wr(fsp_pkg::IDX_MODE, 8'hFE);
    wr(fsp_pkg::IDX_MODE, 8'h02);
    err_done();
    for (int c = 0; c < 8; c++) run(3'(c), 1'b0);
    run(3'h1, 1'b1);
    run(3'h3, 1'b1);
    run(3'h4, 1'b1);
    run(3'h5, 1'b1);
    // Reset after the last run, with the area flag and a command still standing
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(fsp_pkg::IDX_STATUS, 8'h00);
    rd(fsp_pkg::IDX_CMD, 8'h00);
    tally_and_finish();
  end
endmodule
